// File: sfe_host.sv
// Host model: mode-0 serial master, MSB first, one byte per frame.
// Assumes a 100 ns clk_sys; one link bit takes 8 clocks (800 ns).
`timescale 1ns/100ps
module sfe_host (
  input wire clk_sys,
  input wire spi_miso,
  output reg spi_sclk,
  output reg spi_cs_n,
  output reg spi_mosi,
  output reg [7:0] rx_byte,
  output reg rx_done
);
  initial
  begin
    {spi_sclk, spi_cs_n, spi_mosi, rx_done} = 4'h4;
    rx_byte = 8'h00;
  end
  task xfer(input [7:0] tx);
    integer i;
    begin
      @(negedge clk_sys) spi_cs_n = 1'b0;
      for (i = 7; i >= 0; i = i - 1)
      begin
        spi_mosi = tx[i];
        repeat (4) @(negedge clk_sys);
        spi_sclk = 1'b1;
        repeat (4) @(negedge clk_sys);
        // Late sample: the bit was launched well before this edge
        rx_byte[i] = spi_miso;
        spi_sclk = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      spi_cs_n = 1'b1;
      // Released data line shows no stale bit
      spi_mosi = ~spi_mosi;
      rx_done = 1'b1;
      @(negedge clk_sys) rx_done = 1'b0;
      repeat (8) @(negedge clk_sys);
    end
  endtask
endmodule // sfe_host

// File: sfe_map.vh
// Constants for the squib fire-enable timer block: commands, fields, timing.
// Assumes a 10 MHz system clock and an 8-bit mode-0 serial link from the host.
// Overview of operation
// - Continuity command answers 1 per squib with intact low pin, else 0.
// - A continuity result is cleared once shifted out on the next command.
// - Resistance command returns eight comparator bits, 1 when above threshold.
// - Resistance measurements are inhibited while any driver is firing.
// - Loop short test: squib under test bit is 1 on normal current.
// - Loop short test: other bits are 1 when shorted to tested squib.
// - More than two squibs shorted together gives an all-zero answer.
// - Reset low clears functions, shift registers, timers, drivers and programming.
// - Permit low blocks firing; diagnostics stay reachable over the link.
// - After fire command drivers follow permit unless hold keeps it active.
// - A permit counts as active only after staying high past the filter.
// - Permit falling keeps the enable active until its hold timer expires.
// - Hold delay 1 to 255 ms in 1 ms steps, default 0 means none.
// - Hold timer reloads to programmed value when permit rises.
// - Any reset sets both programmed hold delays to zero.
// - Permit diagnostic byte shows the live level of each permit input.
// - Unlock byte clears the delay, the following byte sets it in ms.
// - Programmed delay is shifted back on the following transfer.
// - Every unlock byte is echoed back on the serial data output.
// - Per squib 8-bit step counter runs while driver on and current high.
// - Timing registers clear to zero at power-on and by command.
// - Status command returns current comparators, captured at its own end, shifted out on the next command.
// - Measurement reset command clears timers of squibs whose bit is 1.
`ifndef SFE_MAP_VH
`define SFE_MAP_VH
`define SFE_CLK_KHZ 10000
`define SFE_FILTER_NS 12000
`define SFE_FILTER_CYC ((`SFE_FILTER_NS * `SFE_CLK_KHZ + 999999) / 1000000)
`define SFE_TICK_US 1000
`define SFE_TICK_CYC ((`SFE_TICK_US * `SFE_CLK_KHZ) / 1000)
`define SFE_STEP_CYC 10
`define SFE_HOLD_RESET 8'h00
`define SFE_TIMER_RESET 8'h00
`define SFE_CMD_UNLOCK_A 8'h80
`define SFE_CMD_UNLOCK_B 8'h81
`define SFE_CMD_CONT 8'hc2
`define SFE_CMD_PERMIT 8'hc8
`define SFE_CMD_MEAS_STAT 8'h79
`define SFE_HI_RES 6'h34
`define SFE_HI_LOOP 4'he
`define SFE_HI_MEAS 4'h7
`define SFE_HI_MCLR 4'h3
`define SFE_HI_FIRE 4'ha
`define SFE_SYNC_W 29
`endif

// File: sfe_permit.v
// One fire-permit channel: glitch filter plus programmable hold timer.
// Assumes a synchronised permit level and a one-cycle 1 ms tick.
`timescale 1ns/100ps
`include "sfe_map.vh"
module sfe_permit #(
  parameter FILTER_CYC = `SFE_FILTER_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire permit_in,
  input wire tick_ms,
  input wire [7:0] hold_prog,
  output wire active
);
  reg [7:0] filt_reg;
  reg filt_lvl_reg;
  reg [7:0] hold_reg;

  // Filter stops a short spike from arming the hold, which would turn the
  // latch into a glitch catcher
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_reg <= 8'h00;
      filt_lvl_reg <= 1'b0;
    end
    else if (!permit_in)
    begin
      filt_reg <= 8'h00;
      filt_lvl_reg <= 1'b0;
    end
    else if (filt_reg < FILTER_CYC[7:0])
      filt_reg <= filt_reg + 8'h01;
    else
      filt_lvl_reg <= 1'b1;
  end

  // Hold reloads while high, so a rise always restarts the full delay.
  // The tick is free running: effective hold is between N-1 and N ms.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hold_reg <= `SFE_HOLD_RESET;
    else if (filt_lvl_reg)
      hold_reg <= hold_prog;
    else if (tick_ms && hold_reg != 8'h00)
      hold_reg <= hold_reg - 8'h01;
  end

  assign active = filt_lvl_reg | (hold_reg != 8'h00);
endmodule // sfe_permit

// File: sfe_sync.v
// Two-stage level synchroniser, one bit per lane.
// Assumes inputs are asynchronous to clk_sys and held several clocks.
`timescale 1ns/100ps
module sfe_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // sfe_sync

// File: sfe_top.v
// Digital core of a four-squib driver: serial command slave, permit hold
// timers, firing-current duration counters and latched diagnostic answers.
// Assumes analog comparators deliver levels on pins, asynchronous to clk_sys.
`timescale 1ns/100ps
`include "sfe_map.vh"
module sfe_top #(
  parameter TICK_CYC = `SFE_TICK_CYC,
  parameter STEP_CYC = `SFE_STEP_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  input wire fire_permit_a,
  input wire fire_permit_b,
  input wire [3:0] low_pin_continuity_ok,
  input wire [7:0] res_cmp,
  input wire [3:0] loop_test_current_ok,
  input wire [3:0] loop_shorted_to_tested,
  input wire [3:0] measure_current_threshold,
  output reg [3:0] squib_high_drive,
  output reg [1:0] permit_active
);
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_i_n;

  // Reset release through two flops
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_i_n = rst_sync_reg;

  wire [`SFE_SYNC_W-1:0] sync_w;

  // Select enters inverted so the cleared synchroniser reads as idle after reset,
  // otherwise a false select edge would enable the data output for two clocks
  sfe_sync #(
    .W(`SFE_SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_i_n),
    .async_in({spi_sclk, ~spi_cs_n, spi_mosi, fire_permit_b, fire_permit_a,
      low_pin_continuity_ok, res_cmp, loop_test_current_ok,
      loop_shorted_to_tested, measure_current_threshold}),
    .sync_out(sync_w)
  );

  wire sclk_s = sync_w[28];
  wire cs_n_s = ~sync_w[27];
  wire mosi_s = sync_w[26];
  wire [1:0] permit_s = sync_w[25:24];
  wire [3:0] cont_s = sync_w[23:20];
  wire [7:0] res_s = sync_w[19:12];
  wire [3:0] loop_cur_s = sync_w[11:8];
  wire [3:0] loop_sh_s = sync_w[7:4];
  wire [3:0] meas_s = sync_w[3:0];

  // 1 ms tick and measurement step enables
  reg [13:0] tick_cnt_reg;
  reg tick_reg;
  reg [7:0] step_cnt_reg;
  reg step_reg;

  always @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      tick_cnt_reg <= 14'h0000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == TICK_CYC[13:0] - 14'h0001)
    begin
      tick_cnt_reg <= 14'h0000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 14'h0001;
      tick_reg <= 1'b0;
    end
  end

  always @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      step_cnt_reg <= 8'h00;
      step_reg <= 1'b0;
    end
    else if (step_cnt_reg == STEP_CYC[7:0] - 8'h01)
    begin
      step_cnt_reg <= 8'h00;
      step_reg <= 1'b1;
    end
    else
    begin
      step_cnt_reg <= step_cnt_reg + 8'h01;
      step_reg <= 1'b0;
    end
  end

  // Permit channels
  reg [7:0] hold_a_reg;
  reg [7:0] hold_b_reg;
  wire [1:0] act_w;

  sfe_permit u_permit_a (
    .clk_sys(clk_sys),
    .rst_n(rst_i_n),
    .permit_in(permit_s[0]),
    .tick_ms(tick_reg),
    .hold_prog(hold_a_reg),
    .active(act_w[0])
  );

  sfe_permit u_permit_b (
    .clk_sys(clk_sys),
    .rst_n(rst_i_n),
    .permit_in(permit_s[1]),
    .tick_ms(tick_reg),
    .hold_prog(hold_b_reg),
    .active(act_w[1])
  );

  // Serial slave, mode 0: sample on rising, shift out on falling
  reg sclk_d_reg;
  reg cs_d_reg;
  reg [7:0] rx_reg;
  reg [7:0] tx_reg;
  reg [3:0] bits_reg;
  reg [7:0] resp_reg;
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_fall = ~cs_n_s & cs_d_reg;
  wire cs_rise = cs_n_s & ~cs_d_reg;
  wire cmd_valid = cs_rise && bits_reg == 4'h8;

  always @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      bits_reg <= 4'h0;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_n_s;
      if (cs_fall)
      begin
        tx_reg <= resp_reg;
        bits_reg <= 4'h0;
      end
      else if (!cs_n_s && sclk_rise)
      begin
        rx_reg <= {rx_reg[6:0], mosi_s};
        if (bits_reg != 4'hf)
          bits_reg <= bits_reg + 4'h1;
      end
      else if (!cs_n_s && sclk_fall)
        tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // Loop-short answer packing
  function [7:0] loop_byte;
    input [1:0] sel;
    input [3:0] cur;
    input [3:0] sh;
    reg [3:0] b;
    integer k;
    integer n;
    begin
      b = 4'h0;
      n = 0;
      for (k = 0; k < 4; k = k + 1)
      begin
        if (k == sel)
          b[k] = cur[k];
        else
        begin
          b[k] = sh[k];
          n = n + (sh[k] ? 1 : 0);
        end
      end
      if (n >= 2)
        loop_byte = 8'h00;
      else
        loop_byte = {4'h0, b};
    end
  endfunction

  // Measurement duration counters, one per squib
  reg [3:0] fire_mask_reg;
  reg [3:0] mclr_mask_reg;
  reg [7:0] meas_reg [0:3];
  wire [3:0] drive_w = fire_mask_reg & {act_w[1], act_w[1], act_w[0], act_w[0]};
  wire firing = |squib_high_drive;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_meas
      always @(posedge clk_sys or negedge rst_i_n)
      begin
        if (!rst_i_n)
          meas_reg[g] <= `SFE_TIMER_RESET;
        else if (mclr_mask_reg[g])
          meas_reg[g] <= `SFE_TIMER_RESET;
        else if (squib_high_drive[g] && meas_s[g] && step_reg && meas_reg[g] != 8'hff)
          meas_reg[g] <= meas_reg[g] + 8'h01;
      end
    end
  endgenerate

  // Command decode when select rises after a frame of exactly eight bits
  reg [1:0] unlock_reg;
  reg [7:0] resp_next;

  always @*
  begin
    resp_next = 8'h00;
    if (unlock_reg == 2'b01 || unlock_reg == 2'b10)
      resp_next = rx_reg;
    else if (rx_reg == `SFE_CMD_UNLOCK_A || rx_reg == `SFE_CMD_UNLOCK_B)
      resp_next = rx_reg;
    else if (rx_reg == `SFE_CMD_CONT)
      resp_next = {4'h0, cont_s};
    else if (rx_reg[7:2] == `SFE_HI_RES)
      resp_next = firing ? 8'h00 : res_s;
    else if (rx_reg[7:4] == `SFE_HI_LOOP)
      resp_next = loop_byte(rx_reg[1:0], loop_cur_s, loop_sh_s);
    else if (rx_reg == `SFE_CMD_PERMIT)
      resp_next = {6'h00, permit_s};
    else if (rx_reg == `SFE_CMD_MEAS_STAT)
      resp_next = {4'h0, meas_s};
    else if (rx_reg[7:4] == `SFE_HI_MEAS && rx_reg[3:2] == 2'b00)
      resp_next = meas_reg[rx_reg[1:0]];
  end

  always @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      resp_reg <= 8'h00;
      unlock_reg <= 2'b00;
      hold_a_reg <= `SFE_HOLD_RESET;
      hold_b_reg <= `SFE_HOLD_RESET;
      fire_mask_reg <= 4'h0;
      mclr_mask_reg <= 4'h0;
    end
    else
    begin
      mclr_mask_reg <= 4'h0;
      if (cmd_valid)
      begin
        resp_reg <= resp_next;
        unlock_reg <= 2'b00;
        if (unlock_reg == 2'b01)
          hold_a_reg <= rx_reg;
        else if (unlock_reg == 2'b10)
          hold_b_reg <= rx_reg;
        else if (rx_reg == `SFE_CMD_UNLOCK_A)
        begin
          hold_a_reg <= 8'h00;
          unlock_reg <= 2'b01;
        end
        else if (rx_reg == `SFE_CMD_UNLOCK_B)
        begin
          hold_b_reg <= 8'h00;
          unlock_reg <= 2'b10;
        end
        else if (rx_reg[7:4] == `SFE_HI_FIRE)
          fire_mask_reg <= rx_reg[3:0];
        else if (rx_reg[7:4] == `SFE_HI_MCLR)
          mclr_mask_reg <= rx_reg[3:0];
      end
    end
  end

  // Registered outputs; drivers track permits while the fire mask stands
  always @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
      squib_high_drive <= 4'h0;
      permit_active <= 2'b00;
    end
    else
    begin
      spi_miso <= tx_reg[7];
      spi_miso_oe <= ~cs_n_s;
      squib_high_drive <= drive_w;
      permit_active <= act_w;
    end
  end
endmodule // sfe_top

// File: sfe_top_props.sv
// Checker for the squib fire-enable core, bound onto its top module.
// Assumes permit pins and link traffic follow the hand-over contract.
`timescale 1ns/100ps
module sfe_top_props #(
  parameter TICK_CYC = 10000,
  parameter STEP_CYC = 10
) (
  input wire clk_sys,
  input wire rst_n,
  input wire spi_cs_n,
  input wire spi_miso_oe,
  input wire fire_permit_a,
  input wire [3:0] squib_high_drive,
  input wire [1:0] permit_active
);
  reg [7:0] hi_cnt_reg;
  reg [31:0] lo_cnt_reg;
  // Cycles the raw permit pin has stood high (saturating at 255) or low since it last changed
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      hi_cnt_reg <= 8'h00;
      lo_cnt_reg <= 32'h0;
    end
    else
    begin
      hi_cnt_reg <= fire_permit_a ? hi_cnt_reg + {7'h00, ~&hi_cnt_reg} : 8'h00;
      lo_cnt_reg <= fire_permit_a ? 32'h0 : lo_cnt_reg + 32'h1;
    end
  rst_quiet_a: assert property (@(posedge clk_sys)
    !rst_n |-> squib_high_drive == 4'h0 && permit_active == 2'h0 && !spi_miso_oe)
    else $error("Outputs active in reset");
  release_quiet_a: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> squib_high_drive == 4'h0 ##1 squib_high_drive == 4'h0)
    else $error("Driver on right after reset");
  drive_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    |squib_high_drive[1:0] |-> permit_active[0])
    else $error("Squib 0 or 1 fired without permit a");
  drive_gate_b_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    |squib_high_drive[3:2] |-> permit_active[1])
    else $error("Squib 2 or 3 fired without permit b");
  permit_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(permit_active[0]) |=> squib_high_drive[1:0] == 2'h0)
    else $error("Drivers stayed on after permit dropped");
  filter_min_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(permit_active[0]) |-> hi_cnt_reg >= 8'h78)
    else $error("Permit passed the filter too early");
  filter_max_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hi_cnt_reg == 8'h87 |-> permit_active[0])
    else $error("Permit not active after filter time");
  hold_max_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    permit_active[0] |-> lo_cnt_reg <= 256 * TICK_CYC + 8)
    else $error("Permit held beyond longest hold");
  link_oe_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !spi_cs_n [*8] |-> spi_miso_oe)
    else $error("Data output not enabled in frame");
  link_oe_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("Data output enabled outside frame");
endmodule // sfe_top_props
bind sfe_top sfe_top_props #(.TICK_CYC(TICK_CYC), .STEP_CYC(STEP_CYC)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
  .fire_permit_a(fire_permit_a), .squib_high_drive(squib_high_drive),
  .permit_active(permit_active));

// File: sfe_top_test.sv
// Self-checking bench for the squib fire-enable core.
// Assumes a 50-clock tick stands in for 1 ms to keep holds short.
`timescale 1ns/100ps
`include "sfe_map.vh"
module sfe_top_test;
  reg clk_sys, rst_n, fire_permit_a, fire_permit_b;
  reg [3:0] low_pin_continuity_ok, loop_test_current_ok, loop_shorted_to_tested;
  reg [3:0] measure_current_threshold;
  reg [7:0] res_cmp, v;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, rx_done;
  wire [3:0] squib_high_drive;
  wire [1:0] permit_active;
  wire [7:0] rx_byte;
  reg [7:0] exp_q[$];
  string nm_q[$];
  integer mismatches = 0, checks = 0, i;
  sfe_top #(.TICK_CYC(50), .STEP_CYC(10)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .fire_permit_a(fire_permit_a),
    .fire_permit_b(fire_permit_b), .low_pin_continuity_ok(low_pin_continuity_ok),
    .res_cmp(res_cmp), .loop_test_current_ok(loop_test_current_ok),
    .loop_shorted_to_tested(loop_shorted_to_tested),
    .measure_current_threshold(measure_current_threshold),
    .squib_high_drive(squib_high_drive), .permit_active(permit_active));
  sfe_host host (.clk_sys(clk_sys), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .rx_byte(rx_byte), .rx_done(rx_done));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Notes the expected answer first, since it returns one frame later
  task cmd(input [7:0] c, input [7:0] e, input string nm);
    begin
      exp_q.push_back(e);
      nm_q.push_back(nm);
      host.xfer(c);
    end
  endtask
  // Samples after the wait; drv picks the drivers instead of permit a
  task wait_chk(input integer n, input string nm, input drv, input [7:0] exp);
    begin
      repeat (n) @(negedge clk_sys);
      check(nm, drv ? {4'h0, squib_high_drive} : {7'h0, permit_active[0]}, exp);
    end
  endtask
  task do_reset;
    begin
      rst_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      exp_q.push_back(8'h00);
      nm_q.push_back("reset answer");
    end
  endtask
  function [7:0] loop_exp(input [1:0] t);
    reg [3:0] o;
    begin
      o = loop_shorted_to_tested;
      o[t] = 1'b0;
      loop_exp = ($countones(o) > 1) ? 8'h00 : {4'h0, o | ({3'h0, loop_test_current_ok[t]} << t)};
    end
  endfunction
  // Answer to each command arrives on the following frame
  always @(posedge clk_sys)
    if (rx_done === 1'b1 && exp_q.size() > 0)
      check(nm_q.pop_front(), rx_byte, exp_q.pop_front());
  task complete_run;
    begin
      $display("Counts: checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    #4000000;
    mismatches = mismatches + 1;
    complete_run;
  end
  initial
  begin
    {fire_permit_a, fire_permit_b, measure_current_threshold} = 6'h00;
    {low_pin_continuity_ok, res_cmp, loop_test_current_ok, loop_shorted_to_tested} = 20'h0;
    v = $urandom(47);
    do_reset;
    for (i = 0; i < 8; i = i + 1)
    begin
      {low_pin_continuity_ok, loop_test_current_ok, loop_shorted_to_tested} = $urandom;
      res_cmp = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : $urandom;
      cmd(`SFE_CMD_CONT, {4'h0, low_pin_continuity_ok}, "continuity");
      cmd(8'h00, 8'h00, "cleared continuity");
      cmd({`SFE_HI_RES, i[1:0]}, res_cmp, "resistance");
      cmd({`SFE_HI_LOOP, 2'b00, i[1:0]}, loop_exp(i[1:0]), "loop short");
    end
    $display("Done: diagnostics");
    for (i = 0; i < 4; i = i + 1)
    begin
      {fire_permit_b, fire_permit_a} = i[1:0];
      repeat (6) @(negedge clk_sys);
      cmd(`SFE_CMD_PERMIT, {6'h00, i[1:0]}, "permit level");
    end
    {fire_permit_b, fire_permit_a} = 2'b00;
    v = $urandom;
    cmd(`SFE_CMD_UNLOCK_B, 8'h81, "unlock echo");
    cmd(v, v, "hold readback");
    cmd(`SFE_CMD_UNLOCK_A, 8'h80, "unlock echo");
    cmd(8'h03, 8'h03, "hold readback");
    $display("Done: programming");
    {measure_current_threshold, res_cmp, fire_permit_a} = {4'h1, 8'hff, 1'b1};
    wait_chk(100, "early permit", 1'b0, 8'h00);
    wait_chk(40, "filtered permit", 1'b0, 8'h01);
    cmd({`SFE_HI_FIRE, 4'h3}, 8'h00, "fire answer");
    check("drive on", {4'h0, squib_high_drive}, 8'h03);
    cmd({`SFE_HI_RES, 2'b00}, 8'h00, "inhibited resistance");
    cmd(`SFE_CMD_MEAS_STAT, 8'h01, "current status");
    repeat (2600) @(negedge clk_sys);
    fire_permit_a = 1'b0;
    wait_chk(90, "held drive", 1'b1, 8'h03);
    wait_chk(80, "expired drive", 1'b1, 8'h00);
    fire_permit_a = 1'b1;
    wait_chk(140, "drive back", 1'b1, 8'h03);
    fire_permit_a = 1'b0;
    wait_chk(90, "reloaded hold", 1'b1, 8'h03);
    cmd({`SFE_HI_FIRE, 4'h0}, 8'h00, "fire answer");
    cmd(8'h70, 8'hff, "saturated timer");
    cmd(8'h71, 8'h00, "idle timer");
    cmd({`SFE_HI_MCLR, 4'h1}, 8'h00, "clear answer");
    cmd(8'h70, 8'h00, "cleared timer");
    host.xfer(8'h00);
    $display("Done: firing and timing");
    do_reset;
    fire_permit_a = 1'b1;
    wait_chk(140, "permit after reset", 1'b0, 8'h01);
    fire_permit_a = 1'b0;
    wait_chk(10, "no hold after reset", 1'b0, 8'h00);
    cmd(`SFE_CMD_PERMIT, 8'h00, "permit level");
    host.xfer(8'h00);
    $display("Done: second reset");
    complete_run;
  end
endmodule // sfe_top_test
